// *** src/ifb_fetch_req.v ***
// Overview of operation
// R1: line_size 01 is four words, 10 eight
// R2: Hold attributes stable through acknowledge cycle
// R3: Slave returns aligned quadword for four-word line
// R4: Slave returns aligned eight-word line
// R5: Place data by read_word_index in any order
// R6: cacheable_attr reflects address cacheability
// R7: Non-cacheable size from noncache_line_size_sel
// R8: Non-cacheable line stays in fill buffer only
// R9: Cacheable is eight words, full buffer to cache
// R10: fetch_no_allocate keeps cacheable line out of cache
// R11: Block touch fetches always copy to cache; code copies only cacheable touches, non-cacheable ones stay in the fill buffer
// R12: user_attr reflects user storage attribute
// R13: Slave ignores abort without a request
// R14: Request low two cycles after abort
// R15: Abort with acknowledge returns no data
// R16: Aborted pipelined request dropped, first completes
// R17: Priority from config field, resets to 11
// R18: Slave may acknowledge in first request cycle
// R19: Slave reports width in acknowledge cycle
// R20: One-cycle acknowledge, request low next cycle
// R21: Two outstanding, one low cycle between requests
// R22: Slave answers pipelined requests in order
// R23: Only word address bits are driven
// R24: slave_width low 32-bit, high 64-bit, at acknowledge
// R25: One read_ack per transfer, data taken then
// R26: Third request two cycles after completion
// R27: Reset clears request, abort and fill buffer
`timescale 1ns/10ps
`include "ifb_defines.vh"
module ifb_fetch_req #(
	parameter FIFO_WIDTH = 62,
	parameter FIFO_DEPTH = 32,
	parameter FIFO_AW    = 5
) (
	// Clock and reset
	input  wire        ref_clk,
	input  wire        rst_n,
	// Core fetch requests
	input  wire        core_req_valid,
	input  wire [29:0] core_req_addr,
	input  wire        core_req_cacheable,
	input  wire        core_req_user,
	input  wire        core_req_touch,
	input  wire        core_abort_req,
	output reg         core_req_taken,
	output reg         fetch_aborted,
	output reg         line_done,
	output reg  [1:0]  outstanding,
	// Core lookup into the fill buffer
	input  wire [29:0] core_lookup_addr,
	output wire        core_lookup_hit,
	output wire [31:0] core_lookup_data,
	// Configuration
	input  wire        noncache_line_size_sel,
	input  wire        fetch_no_allocate,
	input  wire        fetch_priority_cfg_wr,
	input  wire [1:0]  fetch_priority_cfg_wdata,
	output reg  [1:0]  fetch_priority_cfg,
	// System bus request
	output reg         fetch_req,
	output reg  [29:0] fetch_addr,
	output reg  [1:0]  line_size,
	output reg         cacheable_attr,
	output reg         user_attr,
	output reg  [1:0]  fetch_priority,
	output reg         fetch_abort,
	input  wire        addr_ack,
	input  wire        slave_width,
	// System bus read data
	input  wire        read_ack,
	input  wire [63:0] read_bus,
	input  wire [2:0]  read_word_index,
	// Cache write port
	output wire        cache_wr_valid,
	output wire [29:0] cache_wr_addr,
	output wire [31:0] cache_wr_data,
	input  wire        cache_wr_ready,
	output reg         cache_copy_busy
);
	localparam [1:0] ST_IDLE = 2'h0;
	localparam [1:0] ST_REQ  = 2'h1;
	localparam [1:0] ST_ABRT = 2'h2;
	localparam [1:0] ST_GAP  = 2'h3;
	localparam [FIFO_AW:0] ROOM_LIM = FIFO_DEPTH - `IFB_LINE_WORDS;

	reg  [1:0]           state_reg;
	reg  [1:0]           state_next;
	reg                  alloc_pend_reg;
	reg  [`IFB_E_W-1:0]  q0_reg;
	reg  [`IFB_E_W-1:0]  q1_reg;
	reg  [1:0]           q_cnt_reg;
	reg  [3:0]           xfer_cnt_reg;
	reg  [1:0]           hold_reg;
	reg  [2:0]           drain_pos_reg;
	reg  [26:0]          drain_tag_reg;
	reg  [3:0]           q0_need;
	wire                 issue_ok;
	wire                 take;
	wire                 push;
	wire                 rd_hit;
	wire                 first;
	wire                 last;
	wire [3:0]           xfer_inc;
	wire [`IFB_E_W-1:0]  new_entry;
	wire                 q0_alloc;
	wire                 q0_size8;
	wire                 q0_w64;
	wire [29:0]          q0_addr;
	wire [2:0]           wr_pos;
	wire                 snap;
	wire [31:0]          drain_data;
	wire                 fifo_s_ready;
	wire [FIFO_AW:0]     fifo_level;
	wire [FIFO_WIDTH-1:0] fifo_m_data;

	assign q0_alloc = q0_reg[`IFB_E_ALLOC];
	assign q0_size8 = q0_reg[`IFB_E_SIZE8];
	assign q0_w64   = q0_reg[`IFB_E_W64];
	assign q0_addr  = q0_reg[`IFB_E_ADDR_HI:0];

	// R21 two outstanding
	// Only a non-allocating line may be followed by a prefetch: its buffer can be reused
	assign issue_ok = ((q_cnt_reg == 2'h0) || ((q_cnt_reg == 2'h1) && !q0_alloc))
	                  && (hold_reg == 2'h0) && !cache_copy_busy && (fifo_level <= ROOM_LIM);
	assign take     = (state_reg == ST_IDLE) && core_req_valid && issue_ok;

	// R20 single acknowledge
	// Acknowledge only counts in a plain request cycle; with abort it is dropped
	assign push     = (state_reg == ST_REQ) && addr_ack;

	// R24 width at acknowledge
	assign new_entry = {alloc_pend_reg, (line_size == `IFB_SIZE_8W), slave_width, fetch_addr};

	// R25 one transfer per acknowledge
	assign rd_hit   = read_ack && (q_cnt_reg != 2'h0);
	assign xfer_inc = xfer_cnt_reg + 4'h1;
	assign first    = rd_hit && (xfer_cnt_reg == 4'h0);
	assign last     = rd_hit && (xfer_inc == q0_need);

	always @*
	begin
		if (q0_size8)
			q0_need = q0_w64 ? `IFB_XFER_8W_64 : `IFB_XFER_8W_32;
		else
			q0_need = q0_w64 ? `IFB_XFER_4W_64 : `IFB_XFER_4W_32;
	end

	// R5 place by index
	// A four-word line sits in the half chosen by its own address
	assign wr_pos = {(q0_size8 ? read_word_index[2] : q0_addr[2]), read_word_index[1],
	                 (q0_w64 ? 1'b0 : read_word_index[0])};

	// R9 full line to cache
	// R10 no allocate holds line
	// R11 cacheable touch always copies
	assign snap = last && q0_alloc;

	always @*
	begin
		case (state_reg)
			ST_IDLE:
				state_next = take ? ST_REQ : ST_IDLE;
			ST_REQ:
			begin
				if (addr_ack)
					state_next = ST_IDLE;
				else if (core_abort_req)
					state_next = ST_ABRT;
				else
					state_next = ST_REQ;
			end
			// R14 gap after abort
			ST_ABRT:
				state_next = ST_GAP;
			ST_GAP:
				state_next = ST_IDLE;
			default:
				state_next = ST_IDLE;
		endcase
	end

	always @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			state_reg      <= ST_IDLE;
			fetch_req      <= 1'b0;
			fetch_abort    <= 1'b0;
			fetch_addr     <= 30'h0000_0000;
			line_size      <= `IFB_SIZE_4W;
			cacheable_attr <= 1'b0;
			user_attr      <= 1'b0;
			fetch_priority <= `IFB_PRIO_RST;
			alloc_pend_reg <= 1'b0;
			core_req_taken <= 1'b0;
			fetch_aborted  <= 1'b0;
		end
		else
		begin
			state_reg      <= state_next;
			// R27 request outputs
			fetch_req      <= (state_next == ST_REQ) || (state_next == ST_ABRT);
			fetch_abort    <= (state_next == ST_ABRT);
			core_req_taken <= take;
			fetch_aborted  <= (state_reg == ST_ABRT);
			// R2 stable attributes
			// Loaded only at issue, so they hold past the acknowledge cycle
			if (take)
			begin
				// R23 word address
				fetch_addr     <= core_req_addr;
				// R6 cacheability
				cacheable_attr <= core_req_cacheable;
				// R12 user attribute
				user_attr      <= core_req_user;
				// R1 size encoding
				// R7 non-cacheable size
				if (core_req_cacheable || noncache_line_size_sel)
					line_size <= `IFB_SIZE_8W;
				else
					line_size <= `IFB_SIZE_4W;
				// R8 non-cacheable stays
				alloc_pend_reg <= core_req_cacheable && (!fetch_no_allocate || core_req_touch);
				// R17 priority
				fetch_priority <= fetch_priority_cfg;
			end
		end
	end

	// R17 priority field
	always @(posedge ref_clk)
	begin
		if (!rst_n)
			fetch_priority_cfg <= `IFB_PRIO_RST;
		else if (fetch_priority_cfg_wr)
			fetch_priority_cfg <= fetch_priority_cfg_wdata;
	end

	// R22 in-order pairing
	// Data always belongs to the oldest entry; the slave keeps issue order
	always @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			q0_reg       <= {`IFB_E_W{1'b0}};
			q1_reg       <= {`IFB_E_W{1'b0}};
			q_cnt_reg    <= 2'h0;
			xfer_cnt_reg <= 4'h0;
			outstanding  <= 2'h0;
			line_done    <= 1'b0;
		end
		else
		begin
			line_done <= last;
			case ({push, last})
				2'b10:
				begin
					if (q_cnt_reg == 2'h0)
						q0_reg <= new_entry;
					else
						q1_reg <= new_entry;
					q_cnt_reg   <= q_cnt_reg + 2'h1;
					outstanding <= q_cnt_reg + 2'h1;
				end
				2'b01:
				begin
					q0_reg      <= q1_reg;
					q_cnt_reg   <= q_cnt_reg - 2'h1;
					outstanding <= q_cnt_reg - 2'h1;
				end
				2'b11:
				begin
					if (q_cnt_reg == 2'h1)
						q0_reg <= new_entry;
					else
					begin
						q0_reg <= q1_reg;
						q1_reg <= new_entry;
					end
				end
				default:
				begin
					q0_reg <= q0_reg;
				end
			endcase
			if (last)
				xfer_cnt_reg <= 4'h0;
			else if (rd_hit)
				xfer_cnt_reg <= xfer_inc;
		end
	end

	// R26 third request spacing
	always @(posedge ref_clk)
	begin
		if (!rst_n)
			hold_reg <= 2'h0;
		else if (last && (q_cnt_reg == 2'h2))
			hold_reg <= `IFB_THIRD_GAP - 2'h1;
		else if (hold_reg != 2'h0)
			hold_reg <= hold_reg - 2'h1;
	end

	// Copy of a finished line into the write queue
	// Room is reserved before issue, so the copy never stalls mid-line
	always @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			cache_copy_busy <= 1'b0;
			drain_pos_reg   <= 3'h0;
			drain_tag_reg   <= 27'h000_0000;
		end
		else if (snap)
		begin
			cache_copy_busy <= 1'b1;
			drain_pos_reg   <= 3'h0;
			drain_tag_reg   <= q0_addr[29:3];
		end
		else if (cache_copy_busy && fifo_s_ready)
		begin
			drain_pos_reg <= drain_pos_reg + 3'h1;
			if (drain_pos_reg == `IFB_LAST_POS)
				cache_copy_busy <= 1'b0;
		end
	end

	// R27 buffer empty at reset
	// R3 quadword placement
	// R4 line placement
	ifb_fill_buf u_fill_buf (
		.clk         (ref_clk),
		.rst_n       (rst_n),
		.start       (first),
		.start_tag   (q0_addr),
		.start_size8 (q0_size8),
		.wr_en       (rd_hit),
		.wr_pos      (wr_pos),
		.wr_two      (q0_w64),
		.wr_data     (read_bus),
		.snap        (snap),
		.rd_pos      (drain_pos_reg),
		.rd_data     (drain_data),
		.lk_addr     (core_lookup_addr),
		.lk_hit_reg  (core_lookup_hit),
		.lk_data_reg (core_lookup_data)
	);

	ifb_fifo #(
		.WIDTH (FIFO_WIDTH),
		.DEPTH (FIFO_DEPTH),
		.AW    (FIFO_AW)
	) u_wr_fifo (
		.clk         (ref_clk),
		.rst_n       (rst_n),
		.s_valid     (cache_copy_busy),
		.s_ready     (fifo_s_ready),
		.s_data      ({drain_tag_reg, drain_pos_reg, drain_data}),
		.m_valid_reg (cache_wr_valid),
		.m_ready     (cache_wr_ready),
		.m_data_reg  (fifo_m_data),
		.level_reg   (fifo_level)
	);

	assign cache_wr_addr = fifo_m_data[61:32];
	assign cache_wr_data = fifo_m_data[31:0];
endmodule // ifb_fetch_req

// *** src/ifb_defines.vh ***
`ifndef IFB_DEFINES_VH
`define IFB_DEFINES_VH

// Line size codes on the bus
`define IFB_SIZE_4W       2'h1
`define IFB_SIZE_8W       2'h2

// Request priority after reset (highest)
`define IFB_PRIO_RST      2'h3

// Cycles from the final read acknowledge of a full pair to a new request
`define IFB_THIRD_GAP     2'h2

// Transfers per line by line size and slave width
`define IFB_XFER_4W_64    4'h2
`define IFB_XFER_4W_32    4'h4
`define IFB_XFER_8W_64    4'h4
`define IFB_XFER_8W_32    4'h8

// Words in one cache line and the last word position
`define IFB_LINE_WORDS    8
`define IFB_LAST_POS      3'h7

// Outstanding request entry layout
`define IFB_E_ALLOC       32
`define IFB_E_SIZE8       31
`define IFB_E_W64         30
`define IFB_E_ADDR_HI     29
`define IFB_E_W           33

`endif

// *** src/ifb_fifo.v ***
`timescale 1ns/10ps
module ifb_fifo #(
	parameter WIDTH = 32,
	parameter DEPTH = 32,
	parameter AW    = 5
) (
	// Clock and reset
	input  wire             clk,
	input  wire             rst_n,
	// Fill side
	input  wire             s_valid,
	output wire             s_ready,
	input  wire [WIDTH-1:0] s_data,
	// Drain side
	output reg              m_valid_reg,
	input  wire             m_ready,
	output reg  [WIDTH-1:0] m_data_reg,
	// Words held in the array
	output reg  [AW:0]      level_reg
);
	// DEPTH must equal 2**AW so the pointers wrap by themselves
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0]    wr_ptr_reg;
	reg [AW-1:0]    rd_ptr_reg;
	wire            push;
	wire            load;
	localparam [AW:0] FULL = DEPTH;

	assign s_ready = (level_reg != FULL);
	assign push    = s_valid && s_ready;
	// Output stage is a register so the drain port is glitch free
	assign load    = (level_reg != {(AW+1){1'b0}}) && (!m_valid_reg || m_ready);

	always @(posedge clk)
	begin
		if (push)
			mem[wr_ptr_reg] <= s_data;
	end

	always @(posedge clk)
	begin
		if (!rst_n)
		begin
			wr_ptr_reg  <= {AW{1'b0}};
			rd_ptr_reg  <= {AW{1'b0}};
			level_reg   <= {(AW+1){1'b0}};
			m_valid_reg <= 1'b0;
			m_data_reg  <= {WIDTH{1'b0}};
		end
		else
		begin
			if (push)
				wr_ptr_reg <= wr_ptr_reg + 1'b1;
			if (load)
			begin
				rd_ptr_reg  <= rd_ptr_reg + 1'b1;
				m_data_reg  <= mem[rd_ptr_reg];
				m_valid_reg <= 1'b1;
			end
			else if (m_ready)
				m_valid_reg <= 1'b0;
			if (push && !load)
				level_reg <= level_reg + 1'b1;
			else if (load && !push)
				level_reg <= level_reg - 1'b1;
		end
	end
endmodule // ifb_fifo

// *** src/ifb_fill_buf.v ***
`timescale 1ns/10ps
`include "ifb_defines.vh"
module ifb_fill_buf (
	// Clock and reset
	input  wire        clk,
	input  wire        rst_n,
	// Line start and data writes
	input  wire        start,
	input  wire [29:0] start_tag,
	input  wire        start_size8,
	input  wire        wr_en,
	input  wire [2:0]  wr_pos,
	input  wire        wr_two,
	input  wire [63:0] wr_data,
	// Snapshot for the cache copy
	input  wire        snap,
	input  wire [2:0]  rd_pos,
	output wire [31:0] rd_data,
	// Fetch lookup
	input  wire [29:0] lk_addr,
	output reg         lk_hit_reg,
	output reg  [31:0] lk_data_reg
);
	reg  [255:0] line_reg;
	reg  [255:0] snap_reg;
	reg  [7:0]   vld_reg;
	reg  [29:0]  tag_reg;
	reg          size8_reg;
	wire [255:0] word_next;
	wire [7:0]   vld_next;
	wire         tag_match;

	genvar i;
	generate
		for (i = 0; i < `IFB_LINE_WORDS; i = i + 1)
		begin : g_word
			localparam [2:0] IDX = i;
			wire hit = wr_en && ((wr_pos == IDX) || (wr_two && ({wr_pos[2:1], 1'b1} == IDX)));
			// Even words ride the upper half of the read bus
			assign word_next[i*32 +: 32] = hit ? (IDX[0] ? wr_data[31:0] : wr_data[63:32])
			                                   : line_reg[i*32 +: 32];
			assign vld_next[i] = hit | (vld_reg[i] & ~start);
		end
	endgenerate

	assign tag_match = size8_reg ? (lk_addr[29:3] == tag_reg[29:3])
	                             : (lk_addr[29:2] == tag_reg[29:2]);
	assign rd_data   = snap_reg[{rd_pos, 5'h00} +: 32];

	always @(posedge clk)
	begin
		if (!rst_n)
		begin
			vld_reg     <= 8'h00;
			tag_reg     <= 30'h0000_0000;
			size8_reg   <= 1'b0;
			line_reg    <= 256'h0;
			snap_reg    <= 256'h0;
			lk_hit_reg  <= 1'b0;
			lk_data_reg <= 32'h0000_0000;
		end
		else
		begin
			vld_reg  <= vld_next;
			line_reg <= word_next;
			if (start)
			begin
				tag_reg   <= start_tag;
				size8_reg <= start_size8;
			end
			// Snapshot includes the word landing this very cycle
			if (snap)
				snap_reg <= word_next;
			lk_hit_reg  <= tag_match && vld_reg[lk_addr[2:0]];
			lk_data_reg <= line_reg[{lk_addr[2:0], 5'h00} +: 32];
		end
	end
endmodule // ifb_fill_buf

// *** tb/ifb_fetch_req_monitor.sv ***
`timescale 1ns/10ps
module ifb_fetch_req_monitor (
	// Clock and reset
	input wire        ref_clk,
	input wire        rst_n,
	// Bus request
	input wire        fetch_req,
	input wire [29:0] fetch_addr,
	input wire [1:0]  line_size,
	input wire        cacheable_attr,
	input wire        user_attr,
	input wire [1:0]  fetch_priority,
	input wire        fetch_abort,
	input wire        addr_ack,
	// Status and configuration
	input wire        read_ack,
	input wire        line_done,
	input wire [1:0]  outstanding,
	input wire        fetch_priority_cfg_wr,
	input wire [1:0]  fetch_priority_cfg_wdata,
	input wire [1:0]  fetch_priority_cfg
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	a_size_code: assert property (fetch_req |-> line_size == 2'h1 || line_size == 2'h2)
		else $error("line size code out of range");
	a_attr_hold: assert property (fetch_req && !addr_ack |=>
		$stable({fetch_addr, line_size, cacheable_attr, user_attr, fetch_priority}))
		else $error("request attributes moved before acknowledge");
	a_cache_eight: assert property (fetch_req && cacheable_attr |-> line_size == 2'h2)
		else $error("cacheable request not eight words");
	a_ack_drop: assert property (fetch_req && addr_ack |=> !fetch_req)
		else $error("request still high after acknowledge");
	a_abort_gap: assert property (fetch_abort |-> fetch_req ##1 !fetch_req [*2])
		else $error("request not low for two cycles after abort");
	a_pair_limit: assert property ($rose(fetch_req) |-> outstanding < 2'h2)
		else $error("third request while two outstanding");
	a_reset_idle: assert property ($rose(rst_n) |-> !fetch_req && !fetch_abort
		&& fetch_priority == 2'h3 && fetch_priority_cfg == 2'h3)
		else $error("wrong state after reset");
	a_prio_write: assert property (fetch_priority_cfg_wr |=>
		fetch_priority_cfg == $past(fetch_priority_cfg_wdata))
		else $error("priority field not written");
	a_done_after: assert property (line_done |-> $past(read_ack))
		else $error("line done without a read acknowledge");
	c_abort: cover property (fetch_abort && addr_ack);
	c_pair: cover property (outstanding == 2'h2);
	c_done: cover property (line_done);
endmodule // ifb_fetch_req_monitor

bind ifb_fetch_req ifb_fetch_req_monitor ifb_fetch_req_monitor_inst (.ref_clk, .rst_n,
	.fetch_req, .fetch_addr, .line_size, .cacheable_attr, .user_attr, .fetch_priority,
	.fetch_abort, .addr_ack, .read_ack, .line_done, .outstanding, .fetch_priority_cfg_wr,
	.fetch_priority_cfg_wdata, .fetch_priority_cfg);

// *** tb/ifb_slave_model.sv ***
`timescale 1ns/10ps
module ifb_slave_model (
	// Clock and reset
	input  wire        ref_clk,
	input  wire        rst_n,
	// Scenario knobs
	input  wire        w64,
	input  wire [1:0]  ack_dly,
	input  wire [1:0]  gap,
	// Request side
	input  wire        fetch_req,
	input  wire [29:0] fetch_addr,
	input  wire [1:0]  line_size,
	input  wire        fetch_abort,
	output wire        addr_ack,
	output wire        slave_width,
	// Read data side
	output reg         read_ack,
	output reg  [63:0] read_bus,
	output reg  [2:0]  read_word_index
);
	reg [31:0] pend[$];
	reg [31:0] e;
	reg [1:0]  wait_cnt;
	reg [1:0]  idle;
	reg [3:0]  t;
	reg [3:0]  n;
	reg [2:0]  p;
	// Ack may come in the first cycle
	assign addr_ack    = fetch_req && (wait_cnt >= ack_dly);
	assign slave_width = w64;
	always @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			pend.delete();
			wait_cnt <= 2'h0;
			idle <= 2'h0;
			t <= 4'h0;
			read_ack <= 1'h0;
			read_bus <= 64'h0000_0000_0000_0000;
			read_word_index <= 3'h0;
		end
		else
		begin
			wait_cnt <= (fetch_req && !addr_ack) ? wait_cnt + 2'h1 : 2'h0;
			// Abort counts only with the acknowledge
			if (addr_ack && !fetch_abort)
				pend.push_back({w64, line_size == 2'h2, fetch_addr});
			read_ack <= 1'h0;
			// Idle bus flips every bit each cycle, showing the last word every other cycle
			read_bus <= ~read_bus;
			read_word_index <= ~read_word_index;
			if (idle != 2'h0)
				idle <= idle - 2'h1;
			else if (pend.size() > 0)
			begin
				// Oldest line first, falling word order
				e = pend[0];
				n = (e[30] ? 4'h8 : 4'h4) >> e[31];
				p = (e[30] ? 3'h0 : {e[2], 2'h0}) + (n - 4'h1 - t) * (e[31] ? 3'h2 : 3'h1);
				read_ack <= 1'h1;
				read_word_index <= p;
				read_bus <= {2'h0, e[29:3], p, 2'h0, e[29:3], p + {2'h0, e[31]}};
				idle <= gap;
				t <= (t == n - 4'h1) ? 4'h0 : t + 4'h1;
				if (t == n - 4'h1)
					e = pend.pop_front();
			end
		end
	end
endmodule // ifb_slave_model

// *** tb/ifb_fetch_req_bench.sv ***
`timescale 1ns/10ps
module ifb_fetch_req_bench;
	reg         ref_clk = 1'h0, rst_n = 1'h0, w64 = 1'h1, ok;
	reg         core_req_valid = 1'h0, core_req_cacheable = 1'h0, core_req_user = 1'h0;
	reg         core_req_touch = 1'h0, core_abort_req = 1'h0, noncache_line_size_sel = 1'h0;
	reg         fetch_no_allocate = 1'h0, fetch_priority_cfg_wr = 1'h0, cache_wr_ready = 1'h1;
	reg  [1:0]  fetch_priority_cfg_wdata = 2'h0, ack_dly = 2'h0, gap = 2'h0;
	reg  [29:0] core_req_addr = 30'h0, core_lookup_addr = 30'h0, wa;
	integer     fail_count = 0, samples_checked = 0, cyc = 0, wr = 0, dn = 0, i, j, k;
	wire        core_req_taken, fetch_aborted, line_done, core_lookup_hit, fetch_req;
	wire        cacheable_attr, user_attr, fetch_abort, addr_ack, slave_width, read_ack;
	wire        cache_wr_valid, cache_copy_busy;
	wire [1:0]  outstanding, fetch_priority_cfg, line_size, fetch_priority;
	wire [29:0] fetch_addr, cache_wr_addr;
	wire [31:0] core_lookup_data, cache_wr_data;
	wire [63:0] read_bus;
	wire [2:0]  read_word_index;
	wire [3:0]  ev = {cache_copy_busy, fetch_aborted, line_done, core_req_taken};

	ifb_fetch_req ifb_fetch_req_inst (.ref_clk, .rst_n, .core_req_valid, .core_req_addr,
		.core_req_cacheable, .core_req_user, .core_req_touch, .core_abort_req, .core_req_taken,
		.fetch_aborted, .line_done, .outstanding, .core_lookup_addr, .core_lookup_hit,
		.core_lookup_data, .noncache_line_size_sel, .fetch_no_allocate, .fetch_priority_cfg_wr,
		.fetch_priority_cfg_wdata, .fetch_priority_cfg, .fetch_req, .fetch_addr, .line_size,
		.cacheable_attr, .user_attr, .fetch_priority, .fetch_abort, .addr_ack, .slave_width,
		.read_ack, .read_bus, .read_word_index, .cache_wr_valid, .cache_wr_addr, .cache_wr_data,
		.cache_wr_ready, .cache_copy_busy);
	ifb_slave_model ifb_slave_model_inst (.ref_clk, .rst_n, .w64, .ack_dly, .gap, .fetch_req,
		.fetch_addr, .line_size, .fetch_abort, .addr_ack, .slave_width, .read_ack, .read_bus,
		.read_word_index);

	always #25 ref_clk = ~ref_clk;

	task check(input [39:0] seen, input [39:0] exp);
	begin
		samples_checked = samples_checked + 1;
		if (seen !== exp)
		begin
			fail_count = fail_count + 1;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	end
	endtask

	task end_sim;
	begin
		$display("checks %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	end
	endtask

	always @(posedge ref_clk)
	begin
		cyc = cyc + 1;
		dn = dn + line_done;
		if (cache_wr_valid && cache_wr_ready)
		begin
			check({cache_wr_addr[2:0], cache_wr_data},
				{wr[2:0], 2'h0, cache_wr_addr[29:3], wr[2:0]});
			wr = wr + 1;
		end
		if (cyc == 20000)
		begin
			fail_count = fail_count + 1;
			end_sim;
		end
	end

	// Step at least one cycle, then wait for one status pulse
	task await(input [1:0] s);
	begin
		j = 0;
		do
		begin
			@(posedge ref_clk);
			#1;
			j = j + 1;
		end
		while (ev[s] !== 1'h1 && j < 300);
	end
	endtask

	task fetch(input [29:0] a, input c, input u, input t);
	begin
		@(posedge ref_clk);
		core_req_addr <= a;
		core_req_cacheable <= c;
		core_req_user <= u;
		core_req_touch <= t;
		core_req_valid <= 1'h1;
		await(0);
		ok = ev[0];
		if (ok)
			check({fetch_req, fetch_priority, line_size, cacheable_attr, user_attr, fetch_addr},
				{1'h1, fetch_priority_cfg_wdata, (c || noncache_line_size_sel) ? 2'h2 : 2'h1,
				c, u, a});
		@(posedge ref_clk) core_req_valid <= 1'h0;
	end
	endtask

	task look(input [29:0] b, input [3:0] n, input h);
	begin
		for (i = 0; i < n; i = i + 1)
		begin
			wa = b + i;
			@(posedge ref_clk) core_lookup_addr <= wa;
			@(posedge ref_clk);
			#1;
			check({core_lookup_hit, h ? core_lookup_data : 32'h0}, {h, h ? {2'h0, wa} : 32'h0});
		end
	end
	endtask

	initial
	begin
		repeat (2) @(posedge ref_clk);
		rst_n <= 1'h1;
		@(posedge ref_clk);
		#1;
		check({fetch_req, fetch_abort, fetch_priority, line_size}, {2'h0, 2'h3, 2'h1});
		$display("test reset done");
		// Every priority code, both widths, acknowledge delays and gaps
		for (k = 0; k < 4; k = k + 1)
		begin
			@(posedge ref_clk);
			fetch_priority_cfg_wr <= 1'h1;
			fetch_priority_cfg_wdata <= k[1:0];
			w64 <= k[0];
			ack_dly <= k[1:0];
			gap <= k[1:0];
			@(posedge ref_clk) fetch_priority_cfg_wr <= 1'h0;
			fetch(30'h100 + k * 8 + 3, 1'h1, k[1], 1'h0);
			await(1);
			check(cache_copy_busy, 1);
			look(30'h100 + k * 8, 8, 1'h1);
		end
		repeat (20) @(posedge ref_clk);
		check(wr, 32);
		$display("test cacheable lines done");
		// Non-cacheable lines of both sizes from a narrow slave
		for (k = 0; k < 2; k = k + 1)
		begin
			@(posedge ref_clk) noncache_line_size_sel <= k[0];
			w64 <= 1'h0;
			fetch(30'h205 + k * 16, 1'h0, 1'h1, 1'h0);
			await(1);
			check(cache_copy_busy, 0);
			look(k ? 30'h210 : 30'h204, k ? 8 : 4, 1'h1);
		end
		look(30'h100, 1, 1'h0);
		check(wr, 32);
		// Without allocation the line stays out, unless it is a touch
		@(posedge ref_clk) fetch_no_allocate <= 1'h1;
		w64 <= 1'h1;
		fetch(30'h300, 1'h1, 1'h0, 1'h0);
		await(1);
		check(cache_copy_busy, 0);
		look(30'h300, 8, 1'h1);
		repeat (20) @(posedge ref_clk);
		check(wr, 32);
		fetch(30'h308, 1'h1, 1'h0, 1'h1);
		await(1);
		repeat (20) @(posedge ref_clk);
		check(wr, 40);
		$display("test allocation done");
		// Abort alone, then abort meeting the acknowledge
		for (k = 0; k < 2; k = k + 1)
		begin
			@(posedge ref_clk) core_abort_req <= 1'h1;
			ack_dly <= k ? 2'h1 : 2'h3;
			fetch(30'h350, 1'h1, 1'h0, 1'h0);
			await(2);
			check(fetch_aborted, 1);
			@(posedge ref_clk) core_abort_req <= 1'h0;
			j = dn;
			repeat (30) @(posedge ref_clk);
			#1;
			check({outstanding, dn}, {2'h0, j});
		end
		$display("test abort done");
		// Two outstanding non-cacheable lines on a slow narrow slave
		@(posedge ref_clk) ack_dly <= 2'h0;
		gap <= 2'h3;
		w64 <= 1'h0;
		fetch(30'h400, 1'h0, 1'h0, 1'h0);
		fetch(30'h408, 1'h0, 1'h0, 1'h0);
		#1;
		check(outstanding, 2);
		await(1);
		await(1);
		look(30'h408, 8, 1'h1);
		$display("test pipelined done");
		// Stall the cache side until the buffer refuses, then drain
		@(posedge ref_clk) gap <= 2'h0;
		w64 <= 1'h1;
		fetch_no_allocate <= 1'h0;
		cache_wr_ready <= 1'h0;
		for (k = 0; k < 5; k = k + 1)
		begin
			fetch(30'h500 + k * 8, 1'h1, 1'h0, 1'h0);
			if (k < 4)
				await(1);
			repeat (12) @(posedge ref_clk);
		end
		check(ok, 0);
		cache_wr_ready <= 1'h1;
		repeat (60) @(posedge ref_clk);
		check(wr, 72);
		$display("test buffer done");
		end_sim;
	end
endmodule // ifb_fetch_req_bench
